// file: logic/cmc_pkg.sv
// shared constants, layouts and types for the macrocell logic block
// Contract
// - OR gate sums up to five product terms
// - cascade chain grows sum to forty terms
// - XOR second input: term, one or zero
// - XOR stage inverts the sum or adds a term; toggle and JK are storage modes
// - data from XOR, own term or pin
// - storage is D, T, JK, SR or latch
// - latch passes while clock high, holds low
// - clock is one of three globals or term
// - D, T, JK and SR storage clocks only on selected rising edge
// - enable term low ignores global clock edges
// - clear is global, term, both or off
// - preset is a term or off
// - output and feedback pick registered independently
// - pin mode and enable source per macrocell
// - input-only pin keeps internal logic usable
// - global bus carries pins and 64 feedbacks
// - switch matrix picks forty bus signals
// - foldback is inverted term on regional bus
// - foldback terms widen sums to nine terms
// - keeper holds last level of undriven pin
// - interrupted programming locks, pins stop driving
// - keeper holds pin levels during programming
package cmc_pkg;
   localparam int NUM_MC = 4;          // macrocells in this region
   localparam int NUM_PT = 5;          // product terms per macrocell
   localparam int NUM_GMC = 64;        // macrocells on the global bus
   localparam int SW_N = 40;           // switch matrix outputs
   localparam int SEL_W = 7;           // bus select width
   localparam logic [SEL_W-1:0] BUS_W = 7'h44; // 4 pins plus 64 feedbacks
   // word offsets on the register bus
   localparam logic [9:0] OFF_SW = 10'h000;     // 40 select words
   localparam logic [9:0] OFF_PT = 10'h040;     // 4 words per term
   localparam logic [9:0] OFF_PT_END = 10'h090;
   localparam logic [9:0] OFF_MC = 10'h0a0;     // one word per macrocell
   localparam logic [9:0] OFF_MC_END = 10'h0a4;
   localparam logic [9:0] OFF_CTRL = 10'h0b0;   // bit 0 keeper enable
   localparam logic [9:0] OFF_STAT = 10'h0b1;   // lock, state, pins
   localparam int CTRL_KEEP_BIT = 0;
   localparam logic [31:0] CFG_RST = 32'h0000_0000;
   // product term roles inside a macrocell
   localparam int PT_CLR = 0;
   localparam int PT_PRE = 1;
   localparam int PT_CLK = 2;
   localparam int PT_DATA = 3;         // also clock enable
   localparam int PT_XOR = 4;          // also K or R input
   typedef enum logic [2:0] {MODE_D = 3'b000, MODE_T = 3'b001, MODE_JK = 3'b010,
      MODE_SR = 3'b011, MODE_LAT = 3'b100} cmc_mode_t;
   typedef enum logic [1:0] {XOR_PT = 2'b00, XOR_ONE = 2'b01, XOR_ZERO = 2'b10} cmc_xsel_t;
   typedef enum logic [1:0] {D_XOR = 2'b00, D_PT = 2'b01, D_PIN = 2'b10} cmc_dsel_t;
   typedef enum logic [1:0] {CK_G0 = 2'b00, CK_G1 = 2'b01, CK_G2 = 2'b10,
      CK_PT = 2'b11} cmc_csel_t;
   typedef enum logic [1:0] {CLR_OFF = 2'b00, CLR_GLB = 2'b01, CLR_PT = 2'b10,
      CLR_BOTH = 2'b11} cmc_clr_t;
   typedef enum logic [2:0] {OE_OFF = 3'b000, OE_ON = 3'b001, OE_P0 = 3'b010,
      OE_P0N = 3'b011, OE_P1 = 3'b100, OE_P1N = 3'b101, OE_PIN = 3'b110,
      OE_MC = 3'b111} cmc_oe_t;
   // macrocell configuration word, msb first
   typedef struct packed {
      logic [1:0] spare;
      logic [2:0] fold_pt;
      logic fold_en;
      logic cas_en;
      logic [4:0] sum_mask;
      logic [1:0] xor_sel;
      logic [1:0] d_sel;
      logic [2:0] mode;
      logic [1:0] clk_sel;
      logic ce_en;
      logic [1:0] clr_sel;
      logic pre_en;
      logic out_reg;
      logic fb_reg;
      logic [2:0] oe_sel;
      logic [1:0] oe_idx;
   } cmc_cfg_t;
   // avalon request from the master
   typedef struct packed {
      logic read;
      logic write;
      logic [11:0] address;
      logic [31:0] writedata;
   } cmc_av_req_t;
endpackage

// file: logic/cmc_top.sv
// one region of four programmable macrocells with pins and a register bus
//
// Chosen here: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/10ps
module cmc_top (
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   input wire cmc_pkg::cmc_av_req_t av_req_i,
   output logic [31:0] av_readdata_o,
   output logic av_waitrequest_o,
   input wire logic [2:0] global_clock_i,
   input wire logic global_clear_i,
   input wire logic [1:0] oe_pin_i,
   input wire logic [cmc_pkg::NUM_MC-1:0] pin_in_i,
   input wire logic [cmc_pkg::NUM_MC-1:0] pin_ext_drv_i,
   output logic [cmc_pkg::NUM_MC-1:0] pin_out_o,
   output logic [cmc_pkg::NUM_MC-1:0] pin_oe_n_o,
   input wire logic [cmc_pkg::NUM_GMC-cmc_pkg::NUM_MC-1:0] ext_feedback_i,
   input wire logic cascade_in_i,
   output logic cascade_out_o,
   output logic [cmc_pkg::NUM_MC-1:0] foldback_o,
   input wire logic isp_active_i,
   input wire logic isp_abort_i,
   output logic isp_locked_o
);
   import cmc_pkg::*;

   // configuration storage
   logic [SEL_W-1:0] sw_sel [SW_N];            // switch matrix selects
   logic [SW_N-1:0] pt_mask [NUM_MC*NUM_PT];   // term uses input
   logic [SW_N-1:0] pt_inv [NUM_MC*NUM_PT];    // term wants input low
   cmc_cfg_t mc_cfg [NUM_MC];                  // per macrocell selections
   logic keeper_en;                            // pin keepers on

   // running state
   logic [NUM_MC-1:0] q_v;       // storage elements
   logic [NUM_MC-1:0] ck_prev;   // last level of each selected clock
   logic [NUM_MC-1:0] keep_v;    // keeper levels
   logic [NUM_MC-1:0] fb_r;      // registered bus feedback

   // combinational nets
   logic [NUM_MC*NUM_PT-1:0] pt_v;   // product terms
   logic [SW_N-1:0] blk_in;          // switch matrix outputs
   logic [NUM_MC-1:0] sum_v;         // OR sums
   logic [NUM_MC:0] cas_v;           // cascade chain
   logic [NUM_MC-1:0] fold_v;        // regional foldback bus
   logic [NUM_MC-1:0] xo_v;          // XOR outputs
   logic [NUM_MC-1:0] out_v;         // pin data
   logic [NUM_MC-1:0] fb_v;          // feedback choice
   logic [NUM_MC-1:0] drive_v;       // pin enables
   logic [NUM_MC-1:0] pin_lvl;       // level seen on each pin
   logic [BUS_W-1:0] gbus;           // global bus

   // ---------------- register bus ----------------
   wire [9:0] word_idx = av_req_i.address[11:2];
   wire req = av_req_i.read | av_req_i.write;
   wire take = req & av_waitrequest_o;              // first edge of a request
   wire commit_wr = av_req_i.write & ~av_waitrequest_o;
   wire in_sw = (word_idx - OFF_SW) < 10'(SW_N);
   wire in_pt = (word_idx >= OFF_PT) && (word_idx < OFF_PT_END);
   wire in_mc = (word_idx >= OFF_MC) && (word_idx < OFF_MC_END);
   wire in_ctrl = word_idx == OFF_CTRL;
   wire in_stat = word_idx == OFF_STAT;
   wire [9:0] pt_word = word_idx - OFF_PT;
   wire [4:0] pt_idx = pt_word[6:2];
   wire [9:0] mc_word = word_idx - OFF_MC;
   wire [1:0] mc_idx = mc_word[1:0];
   wire [5:0] sw_idx = word_idx[5:0];
   wire [SW_N-1:0] pm_rd = pt_mask[pt_idx];
   wire [SW_N-1:0] pi_rd = pt_inv[pt_idx];
   // term words: mask low, mask high, invert low, invert high
   wire [31:0] pt_rd = (pt_word[1:0] == 2'h0) ? pm_rd[31:0] :
                       (pt_word[1:0] == 2'h1) ? {24'h0, pm_rd[39:32]} :
                       (pt_word[1:0] == 2'h2) ? pi_rd[31:0] : {24'h0, pi_rd[39:32]};
   wire [31:0] stat_rd = {23'h0, isp_locked_o, q_v, pin_lvl};
   wire [31:0] rd_val = in_sw ? {25'h0, sw_sel[sw_idx]} :
                        in_pt ? pt_rd :
                        in_mc ? 32'(mc_cfg[mc_idx]) :
                        in_ctrl ? {31'h0, keeper_en} :
                        in_stat ? stat_rd : 32'h0;

   // one wait cycle per request, data stands with the release
   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         av_waitrequest_o <= 1'b1;
         av_readdata_o <= 32'h0;
      end else begin
         av_waitrequest_o <= ~take;
         if (take) begin
            av_readdata_o <= rd_val;
         end
      end
   end

   // configuration writes, loaded before the logic runs
   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         keeper_en <= 1'b0;
         for (int i = 0; i < SW_N; i++) begin
            sw_sel[i] <= '0;
         end
         for (int i = 0; i < NUM_MC*NUM_PT; i++) begin
            pt_mask[i] <= '0;
            pt_inv[i] <= '0;
         end
         for (int i = 0; i < NUM_MC; i++) begin
            mc_cfg[i] <= cmc_cfg_t'(CFG_RST);
         end
      end else if (commit_wr) begin
         if (in_sw) begin
            sw_sel[sw_idx] <= av_req_i.writedata[SEL_W-1:0];
         end
         if (in_pt) begin
            unique case (pt_word[1:0])
               2'h0: pt_mask[pt_idx][31:0] <= av_req_i.writedata;
               2'h1: pt_mask[pt_idx][39:32] <= av_req_i.writedata[7:0];
               2'h2: pt_inv[pt_idx][31:0] <= av_req_i.writedata;
               2'h3: pt_inv[pt_idx][39:32] <= av_req_i.writedata[7:0];
            endcase
         end
         if (in_mc) begin
            mc_cfg[mc_idx] <= cmc_cfg_t'(av_req_i.writedata);
         end
         if (in_ctrl) begin
            keeper_en <= av_req_i.writedata[CTRL_KEEP_BIT];
         end
      end
   end

   // ---------------- global bus and switch matrix ----------------
   assign gbus = {ext_feedback_i, fb_r, pin_lvl};
   for (genvar j = 0; j < SW_N; j++) begin : g_sw
      // out of range select feeds a quiet zero
      assign blk_in[j] = (sw_sel[j] < BUS_W) ? gbus[sw_sel[j]] : 1'b0;
   end
   // empty term is off, not on
   for (genvar p = 0; p < NUM_MC*NUM_PT; p++) begin : g_pt
      assign pt_v[p] = (|pt_mask[p]) & (&(~pt_mask[p] | ~(blk_in ^ ~pt_inv[p])));
   end
   assign cas_v[0] = cascade_in_i;

   // ---------------- macrocells ----------------
   for (genvar m = 0; m < NUM_MC; m++) begin : g_mc
      localparam int B = m * NUM_PT;
      wire [NUM_PT-1:0] pts = pt_v[B +: NUM_PT];
      cmc_cfg_t c;
      logic x2;        // second XOR input
      logic d;         // data into storage
      logic ck;        // selected clock level
      logic rise;      // rising edge of it
      logic ce_ok;     // edge allowed
      logic clr;       // clear request
      logic pre;       // preset request
      logic oe;        // selected enable
      logic next_q;    // next storage value
      assign c = mc_cfg[m];

      // foldback is an inverted term of this cell
      assign fold_v[m] = (c.fold_pt < 3'(NUM_PT)) & ~pts[c.fold_pt];
      // own terms, cascade from the left neighbour, regional foldbacks
      assign sum_v[m] = (|(pts & c.sum_mask)) |
                        (c.cas_en & cas_v[m]) |
                        (c.fold_en & (|fold_v));
      assign cas_v[m+1] = sum_v[m];
      assign x2 = (c.xor_sel == XOR_PT) ? pts[PT_XOR] : (c.xor_sel == XOR_ONE);
      assign xo_v[m] = sum_v[m] ^ x2;
      assign d = (c.d_sel == D_PT) ? pts[PT_DATA] :
                 (c.d_sel == D_PIN) ? pin_lvl[m] : xo_v[m];
      assign ck = (c.clk_sel == CK_PT) ? pts[PT_CLK] : global_clock_i[c.clk_sel];
      assign rise = ck & ~ck_prev[m];
      // enable term only gates global clocks
      assign ce_ok = (c.clk_sel == CK_PT) | ~c.ce_en | pts[PT_DATA];
      assign clr = (c.clr_sel[0] & global_clear_i) | (c.clr_sel[1] & pts[PT_CLR]);
      assign pre = c.pre_en & pts[PT_PRE];

      // storage next state, clear over preset over clocking
      always_comb begin
         next_q = q_v[m];
         if (clr) begin
            next_q = 1'b0;
         end else if (pre) begin
            next_q = 1'b1;
         end else if (c.mode == MODE_LAT) begin
            next_q = ck ? d : q_v[m];
         end else if (rise && ce_ok) begin
            unique case (c.mode)
               MODE_D: next_q = d;
               MODE_T: next_q = q_v[m] ^ d;
               MODE_JK: next_q = (d & ~q_v[m]) | (~pts[PT_XOR] & q_v[m]);
               MODE_SR: next_q = d | (~pts[PT_XOR] & q_v[m]);
               default: next_q = q_v[m];
            endcase
         end
      end

      // pin enable source
      always_comb begin
         unique case (c.oe_sel)
            OE_OFF: oe = 1'b0;
            OE_ON: oe = 1'b1;
            OE_P0: oe = oe_pin_i[0];
            OE_P0N: oe = ~oe_pin_i[0];
            OE_P1: oe = oe_pin_i[1];
            OE_P1N: oe = ~oe_pin_i[1];
            OE_PIN: oe = pin_lvl[c.oe_idx];
            OE_MC: oe = xo_v[c.oe_idx];
         endcase
      end

      assign out_v[m] = c.out_reg ? q_v[m] : xo_v[m];
      assign fb_v[m] = c.fb_reg ? q_v[m] : xo_v[m];
      // programming or its failure stops every pin driver
      assign drive_v[m] = oe & ~(isp_locked_o | isp_abort_i | isp_active_i);
      // own driver first, then outside driver, then keeper
      assign pin_lvl[m] = ~pin_oe_n_o[m] ? pin_out_o[m] :
                          pin_ext_drv_i[m] ? pin_in_i[m] : (keeper_en & keep_v[m]);

      // storage, edge memory, keeper and pin registers
      always_ff @(posedge clk_sys_i) begin
         if (!reset_n_i) begin
            q_v[m] <= 1'b0;
            ck_prev[m] <= 1'b0;
            keep_v[m] <= 1'b0;
            fb_r[m] <= 1'b0;
            pin_out_o[m] <= 1'b0;
            pin_oe_n_o[m] <= 1'b1;
            foldback_o[m] <= 1'b0;
         end else begin
            if (!isp_locked_o) begin
               q_v[m] <= next_q;
            end
            ck_prev[m] <= ck;
            // frozen while programming runs
            if ((!pin_oe_n_o[m] || pin_ext_drv_i[m]) && !isp_active_i) begin
               keep_v[m] <= pin_lvl[m];
            end
            fb_r[m] <= fb_v[m];
            pin_out_o[m] <= out_v[m];
            pin_oe_n_o[m] <= ~drive_v[m];
            foldback_o[m] <= fold_v[m];
         end
      end
   end

   // cascade leaves the region and lock latches until reset
   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         cascade_out_o <= 1'b0;
         isp_locked_o <= 1'b0;
      end else begin
         cascade_out_o <= cas_v[NUM_MC];
         isp_locked_o <= isp_locked_o | isp_abort_i;
      end
   end

   // ---------------- checks ----------------
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!reset_n_i);

   // helper views of macrocell zero and of the cascade enables of all four cells
   wire c0_plain = (mc_cfg[0].clr_sel == CLR_OFF) && !mc_cfg[0].pre_en;
   wire c0_comb = !mc_cfg[0].out_reg && !mc_cfg[0].cas_en && !mc_cfg[0].fold_en;
   wire all_cas = &{mc_cfg[0].cas_en, mc_cfg[1].cas_en, mc_cfg[2].cas_en,
      mc_cfg[3].cas_en};

   sequence s_req_taken;
      req && av_waitrequest_o;
   endsequence
   sequence s_released;
      !av_waitrequest_o ##1 av_waitrequest_o;
   endsequence
   sequence s_prog_hold;
      keeper_en && isp_active_i;
   endsequence

   chk_bus_one_wait: assert property (s_req_taken |=> s_released)
      else $error("bus answer not one cycle after request");
   chk_or_sum: assert property (c0_comb && mc_cfg[0].xor_sel == XOR_ZERO
         && |(pt_v[4:0] & mc_cfg[0].sum_mask) |=> pin_out_o[0])
      else $error("sum of terms did not reach the pin");
   chk_cascade_chain: assert property (all_cas && cascade_in_i |=> cascade_out_o)
      else $error("cascade did not pass through the region");
   chk_xor_polarity: assert property (c0_comb && mc_cfg[0].xor_sel == XOR_ONE
         && !(|(pt_v[4:0] & mc_cfg[0].sum_mask)) |=> pin_out_o[0])
      else $error("fixed one did not invert an empty sum");
   chk_ce_ignores: assert property (c0_plain && mc_cfg[0].ce_en
         && mc_cfg[0].clk_sel != CK_PT && !pt_v[PT_DATA] && !isp_locked_o
         && mc_cfg[0].mode != MODE_LAT |=> $stable(q_v[0]))
      else $error("edge taken while enable term low");
   chk_latch_hold: assert property (c0_plain && mc_cfg[0].mode == MODE_LAT
         && !g_mc[0].ck |=> $stable(q_v[0]))
      else $error("latch changed while clock low");
   chk_clear_wins: assert property (g_mc[0].clr && !isp_locked_o |=> !q_v[0])
      else $error("clear did not empty the storage");
   chk_preset_sets: assert property (g_mc[0].pre && !g_mc[0].clr
         && !isp_locked_o |=> q_v[0])
      else $error("preset did not set the storage");
   chk_isp_hiz: assert property (isp_abort_i |=> (isp_locked_o && &pin_oe_n_o) [*3])
      else $error("pins still driven after programming stopped");
   chk_keeper_prog: assert property (s_prog_hold |=> $stable(keep_v))
      else $error("keeper moved during programming");
   chk_fb_choice: assert property (mc_cfg[0].fb_reg && !mc_cfg[0].out_reg
         |=> fb_r[0] == $past(q_v[0]))
      else $error("feedback did not follow the register");
endmodule

// file: tb/cmc_top_test.sv
// self-checking bench for the four-macrocell region
`timescale 1ns/10ps
module cmc_top_test;
   import cmc_pkg::*;
   // one row: cell 0 sum, xor, enable choice, bus inputs, expected pin
   typedef struct packed {
      logic [4:0] sm;
      logic [1:0] xs;
      logic [2:0] oe;
      logic [1:0] fb; // {ext_fb[59], ext_fb[0]}
      logic pin;
      logic oen;
   } cmc_row_t;
   logic clk_sys; // 10 MHz system clock
   logic reset_n; // synchronous, active low
   cmc_av_req_t av_req; // bus request
   logic [31:0] rdata;
   logic wait_req;
   logic [2:0] gclk; // global clock lines
   logic gclr;
   logic [3:0] pin_in, pin_drv, pin_out, pin_oe_n, fold;
   logic [59:0] ext_fb; // other macrocells
   logic cas_out, cas_in, isp_act, isp_abt, locked;
   logic [1:0] oe_pins; // dedicated enable pins
   logic [31:0] rd; // last read value
   int miscompares, num_checks;
   // combinational cases of cell 0
   cmc_row_t rows [8] = '{
      '{5'h08, XOR_ZERO, OE_ON, 2'h2, 1'h1, 1'h0},
      '{5'h08, XOR_ONE, OE_ON, 2'h2, 1'h0, 1'h0},
      '{5'h08, XOR_ONE, OE_ON, 2'h0, 1'h1, 1'h0},
      '{5'h08, XOR_PT, OE_ON, 2'h3, 1'h0, 1'h0},
      '{5'h08, XOR_PT, OE_ON, 2'h2, 1'h1, 1'h0},
      '{5'h18, XOR_ZERO, OE_ON, 2'h1, 1'h1, 1'h0},
      '{5'h18, XOR_ZERO, OE_P0N, 2'h0, 1'h0, 1'h0},
      '{5'h00, XOR_ZERO, OE_P0, 2'h3, 1'h0, 1'h1}};
   logic [9:0] roffs [4] = '{10'h0a0, 10'h000, 10'h04c, 10'h0b0}; // config places
   cmc_top u_dut (.clk_sys_i(clk_sys), .reset_n_i(reset_n), .av_req_i(av_req),
      .av_readdata_o(rdata), .av_waitrequest_o(wait_req), .global_clock_i(gclk),
      .global_clear_i(gclr), .oe_pin_i(oe_pins), .pin_in_i(pin_in), .pin_ext_drv_i(pin_drv),
      .pin_out_o(pin_out), .pin_oe_n_o(pin_oe_n), .ext_feedback_i(ext_fb),
      .cascade_in_i(cas_in), .cascade_out_o(cas_out), .foldback_o(fold),
      .isp_active_i(isp_act), .isp_abort_i(isp_abt), .isp_locked_o(locked));
   // free-running clock
   initial begin
      clk_sys = 1'h0;
      forever #50 clk_sys = ~clk_sys;
   end
   // verdict and end of run
   task automatic stop_test();
      if (miscompares == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // compare seen with expected
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         $display("BAD %s expected %h seen %h", name, exp, seen);
         miscompares++;
      end
   endtask
   // go to a rising edge before driving
   task automatic step(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   // let n edges pass, then sample settled outputs
   task automatic look(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   // one avalon transfer, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [9:0] off, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge clk_sys);
      av_req <= '{read: ~wr, write: wr, address: {off, 2'h0}, writedata: wd};
      do begin
         @(posedge clk_sys);
         n++;
      end while (wait_req !== 1'h0 && n < 20);
      rd = rdata;
      av_req <= '0;
      if (n >= 20) begin
         $display("BAD bus_wait expected 0 seen 1");
         miscompares++;
         stop_test();
      end
   endtask
   // cell config word, fold term 3
   function automatic logic [31:0] cfg(logic [4:0] sm, logic [1:0] xs, logic [1:0] ds,
      logic [2:0] md, logic [1:0] ck, logic ce, logic [1:0] cl, logic orr, logic [2:0] oe);
      cmc_cfg_t c;
      c = '0;
      c.fold_pt = 3'h3;
      c.sum_mask = sm;
      c.xor_sel = xs;
      c.d_sel = ds;
      c.mode = md;
      c.clk_sel = ck;
      c.ce_en = ce;
      c.clr_sel = cl;
      c.out_reg = orr;
      c.fb_reg = ~orr; // feedback taken the other way
      c.oe_sel = oe;
      return c;
   endfunction
   // reset held 6 edges, outputs at their reset level after 5
   task automatic do_reset();
      step(1);
      reset_n <= 1'h0;
      look(5);
      chk("reset_out", {17'h0, wait_req, locked, cas_out, fold, pin_oe_n, pin_out},
         {17'h0, 1'h1, 1'h0, 1'h0, 4'h0, 4'hf, 4'h0});
      chk("reset_rdata", rdata, 32'h0);
      step(1);
      reset_n <= 1'h1;
   endtask
   // one cycle pulse on global clock k, then settle
   task automatic pulse(input int k);
      step(1);
      gclk[k] <= 1'h1;
      step(1);
      gclk[k] <= 1'h0;
      look(3);
   endtask
   // new level of the far feedback feeding term 3
   task automatic fbv(input logic v);
      step(1);
      ext_fb <= {v, 59'h0};
   endtask
   // far feedback levels on terms 3 and 4
   task automatic fb2(input logic hi, input logic lo);
      step(1);
      ext_fb <= {hi, 58'h0, lo};
   endtask
   // main sequence
   initial begin
      reset_n = 1'h0;
      av_req = '0;
      gclk = 3'h0;
      gclr = 1'h0;
      oe_pins = 2'h0;
      cas_in = 1'h0;
      pin_in = 4'h0;
      pin_drv = 4'h0;
      ext_fb = '0;
      isp_act = 1'h0;
      isp_abt = 1'h0;
      miscompares = 0;
      num_checks = 0;
      do_reset();
      foreach (roffs[i]) begin
         bus(1'h0, roffs[i], 32'h0);
         chk("cfg_reset", rd, CFG_RST);
      end
      bus(1'h1, 10'h0f0, 32'hffff_ffff); // unmapped place
      bus(1'h0, 10'h0f0, 32'h0);
      chk("unmapped", rd, 32'h0);
      // switches 0 and 39 pick bus bits 8 and 67, terms 4 and 3 use them
      bus(1'h1, 10'h000, 32'h8);
      bus(1'h1, 10'h027, 32'h43);
      bus(1'h1, 10'h04d, 32'h80);
      bus(1'h1, 10'h050, 32'h1);
      foreach (rows[i]) begin
         bus(1'h1, 10'h0a0, cfg(rows[i].sm, rows[i].xs, D_XOR, MODE_D, CK_G0, 1'h0,
            CLR_OFF, 1'h0, rows[i].oe));
         bus(1'h0, 10'h0a0, 32'h0);
         chk("cfg_back", rd, cfg(rows[i].sm, rows[i].xs, D_XOR, MODE_D, CK_G0, 1'h0,
            CLR_OFF, 1'h0, rows[i].oe));
         step(1);
         ext_fb <= {rows[i].fb[1], 58'h0, rows[i].fb[0]};
         look(3);
         chk("pin_out", {28'h0, pin_out}, {31'h0, rows[i].pin});
         chk("pin_oe_n", {28'h0, pin_oe_n}, {28'h0, 3'h7, rows[i].oen});
         chk("foldback", {31'h0, fold[0]}, {31'h0, ~rows[i].fb[1]});
      end
      // enable from pin 1, true polarity
      bus(1'h1, 10'h0a0, cfg(5'h0, XOR_ZERO, D_XOR, MODE_D, CK_G0, 1'h0, CLR_OFF, 1'h0, OE_P1));
      step(1);
      oe_pins <= 2'h2;
      look(3);
      chk("oe_p1_high", {28'h0, pin_oe_n}, 32'he);
      step(1);
      oe_pins <= 2'h1;
      look(3);
      chk("oe_p1_low", {28'h0, pin_oe_n}, 32'hf);
      // registered d from own term, global clock 0
      bus(1'h1, 10'h0a0, cfg(5'h0, XOR_ZERO, D_PT, MODE_D, CK_G0, 1'h0, CLR_OFF, 1'h1, OE_ON));
      fbv(1'h0);
      look(4);
      chk("d_idle", {28'h0, pin_out}, 32'h0);
      fbv(1'h1);
      look(4);
      chk("d_noedge", {28'h0, pin_out}, 32'h0);
      pulse(0);
      chk("d_rise", {28'h0, pin_out}, 32'h1);
      // clock 1 selected: clock 0 ignored
      bus(1'h1, 10'h0a0, cfg(5'h0, XOR_ZERO, D_PT, MODE_D, CK_G1, 1'h0, CLR_OFF, 1'h1, OE_ON));
      fbv(1'h0);
      pulse(0);
      chk("ck_other", {28'h0, pin_out}, 32'h1);
      pulse(1);
      chk("ck_sel", {28'h0, pin_out}, 32'h0);
      // clock enable shares term 3 with data
      bus(1'h1, 10'h0a0, cfg(5'h0, XOR_ZERO, D_PT, MODE_D, CK_G0, 1'h1, CLR_OFF, 1'h1, OE_ON));
      fbv(1'h1);
      pulse(0);
      chk("ce_high", {28'h0, pin_out}, 32'h1);
      fbv(1'h0);
      pulse(0);
      chk("ce_low", {28'h0, pin_out}, 32'h1);
      // toggle with t input high
      bus(1'h1, 10'h0a0, cfg(5'h0, XOR_ZERO, D_PT, MODE_T, CK_G0, 1'h0, CLR_OFF, 1'h1, OE_ON));
      fbv(1'h1);
      pulse(0);
      chk("t_first", {28'h0, pin_out}, 32'h0);
      pulse(0);
      chk("t_second", {28'h0, pin_out}, 32'h1);
      // jk then sr: term 3 is j or s, term 4 is k or r
      bus(1'h1, 10'h0a0, cfg(5'h0, XOR_ZERO, D_PT, MODE_JK, CK_G0, 1'h0, CLR_OFF, 1'h1, OE_ON));
      fb2(1'h0, 1'h1);
      pulse(0);
      chk("jk_k", {28'h0, pin_out}, 32'h0);
      fb2(1'h1, 1'h1);
      pulse(0);
      chk("jk_toggle", {28'h0, pin_out}, 32'h1);
      bus(1'h1, 10'h0a0, cfg(5'h0, XOR_ZERO, D_PT, MODE_SR, CK_G0, 1'h0, CLR_OFF, 1'h1, OE_ON));
      fb2(1'h0, 1'h1);
      pulse(0);
      chk("sr_reset", {28'h0, pin_out}, 32'h0);
      fb2(1'h1, 1'h1);
      pulse(0);
      chk("sr_set_wins", {28'h0, pin_out}, 32'h1);
      fbv(1'h1);
      // global clear drops the state
      bus(1'h1, 10'h0a0, cfg(5'h0, XOR_ZERO, D_PT, MODE_D, CK_G0, 1'h0, CLR_GLB, 1'h1, OE_ON));
      step(1);
      gclr <= 1'h1;
      look(3);
      chk("clear", {28'h0, pin_out}, 32'h0);
      step(1);
      gclr <= 1'h0;
      // preset from term 1, which follows bus bit 8
      bus(1'h1, 10'h044, 32'h1);
      bus(1'h1, 10'h0a0, cfg(5'h0, XOR_ZERO, D_PT, MODE_D, CK_G0, 1'h0, CLR_OFF, 1'h1,
         OE_ON) | 32'h80);
      fb2(1'h0, 1'h1);
      look(3);
      chk("preset", {28'h0, pin_out}, 32'h1);
      fbv(1'h1);
      // latch: transparent while clock high, holds while low
      bus(1'h1, 10'h0a0, cfg(5'h0, XOR_ZERO, D_PT, MODE_LAT, CK_G0, 1'h0, CLR_OFF, 1'h1, OE_ON));
      step(1);
      gclk[0] <= 1'h1;
      look(3);
      chk("lat_open", {28'h0, pin_out}, 32'h1);
      fbv(1'h0);
      look(3);
      chk("lat_pass", {28'h0, pin_out}, 32'h0);
      step(1);
      gclk[0] <= 1'h0;
      fbv(1'h1);
      look(3);
      chk("lat_hold", {28'h0, pin_out}, 32'h0);
      // keeper on pin 1, an input-only pin
      bus(1'h1, 10'h0b0, 32'h1);
      step(1);
      pin_drv <= 4'h2;
      pin_in <= 4'h2;
      look(3);
      step(1);
      pin_drv <= 4'h0;
      pin_in <= 4'hd; // released line shows junk
      look(3);
      bus(1'h0, 10'h0b1, 32'h0);
      chk("keep_on", {31'h0, rd[1]}, 32'h1);
      bus(1'h1, 10'h0b0, 32'h0);
      look(3);
      bus(1'h0, 10'h0b1, 32'h0);
      chk("keep_off", {31'h0, rd[1]}, 32'h0);
      // programming, then abort locks the pins off
      chk("oe_run", {28'h0, pin_oe_n}, 32'he);
      step(1);
      isp_act <= 1'h1;
      look(3);
      chk("oe_isp", {28'h0, pin_oe_n}, 32'hf);
      // keeper on: a level driven during programming is not taken
      bus(1'h1, 10'h0b0, 32'h1);
      step(1);
      pin_drv <= 4'h2;
      pin_in <= 4'h0;
      look(3);
      step(1);
      pin_drv <= 4'h0;
      look(3);
      bus(1'h0, 10'h0b1, 32'h0);
      chk("keep_isp", {31'h0, rd[1]}, 32'h1);
      step(1);
      isp_abt <= 1'h1;
      step(1);
      isp_abt <= 1'h0;
      isp_act <= 1'h0;
      look(12);
      chk("lock", {27'h0, locked, pin_oe_n}, 32'h1f);
      bus(1'h0, 10'h0b1, 32'h0);
      chk("lock_stat", {31'h0, rd[8]}, 32'h1);
      // cascade through all four cells, pins left as inputs
      for (int m = 0; m < 4; m++) begin
         bus(1'h1, 10'h0a0 + 10'(m), cfg(5'h0, XOR_ZERO, D_XOR, MODE_D, CK_G0, 1'h0, CLR_OFF,
            1'h0, OE_OFF) | 32'h0200_0000);
      end
      step(1);
      cas_in <= 1'h1;
      look(3);
      chk("cas_on", {31'h0, cas_out}, 32'h1);
      chk("cas_pins", {28'h0, pin_out}, 32'hf);
      step(1);
      cas_in <= 1'h0;
      look(3);
      chk("cas_off", {31'h0, cas_out}, 32'h0);
      do_reset();
      stop_test();
   end
endmodule
